/* File: logic/usd_pkg.sv */
// What this block does
// - One internal stall bit per endpoint, consulted on every host transaction except a setup to the control endpoint.
// - Software cannot clear a stall bit; host Clear Feature or a bus reset clears it.
// - Control endpoint stall bit also clears when a setup is received there.
// - Writing a stall request bit leaves the internal bit untouched until a transaction.
// - Transaction with clear stall bit but request set sets the bit, answers STALL.
// - Both bits clear: stall bit unchanged, transaction processed normally.
// - After Clear Feature, stall is re-set on each transaction while request stays set.
// - Set Feature halt or protocol violation sets stall bit, answers STALL.
// - DMA only for receive endpoint 1 and transmit endpoint 2, byte accesses only.
// - Receive DMA request while selected side holds at least one valid byte.
// - With receive DMA enabled, zero-length packets are dropped, not stored.
// - Under receive DMA, draining the selected side frees it and switches sides.
// - Transmit DMA request whenever the fill side has free space.
// - Under transmit DMA, a 64-byte fill arms that side and switches sides.
// - Inhibited pull-up with cable attached, both lines low, acts as bus reset.
// - While bus power sense is low, powered state reads 0, data lines ignored.
// - Suspend routing set drives one external line from suspend, one from wake.
// - Set-configuration reception is flagged and config valid reads 1.
// - Two 64-byte sides per bulk endpoint; receive answers NAK when both full.
package usd_pkg;

  localparam int          EP_BITS          = 2;
  localparam logic [1:0]  EP_CTRL          = 2'h0;
  localparam logic [1:0]  EP_RX            = 2'h1;
  localparam logic [1:0]  EP_TX            = 2'h2;
  localparam logic [6:0]  MAX_PKT          = 7'h40;

  localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
  localparam logic [7:0]  ADDR_TRIGGER     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS      = 8'h08;
  localparam logic [7:0]  ADDR_FLAGS       = 8'h0c;

  localparam int          CTL_RX_DMA       = 4;
  localparam int          CTL_TX_DMA       = 5;
  localparam int          CTL_SUSP_ROUTE   = 6;
  localparam int          TRG_READ_FINISH  = 0;
  localparam int          TRG_PACKET_EN    = 1;
  localparam int          ST_RX_REQ        = 4;
  localparam int          ST_TX_REQ        = 5;
  localparam int          ST_CFG_VALID     = 6;
  localparam int          ST_BUS_RESET     = 7;
  localparam int          ST_POWERED       = 8;
  localparam int          ST_RX_SEL        = 9;
  localparam int          ST_TX_WSEL       = 10;
  localparam int          ST_TX_RSEL       = 11;
  localparam int          ST_RX_FULL       = 12;
  localparam int          ST_TX_FULL       = 14;
  localparam int          ST_RX_CNT        = 16;
  localparam int          FLG_SET_CONFIG   = 0;
  localparam int          FLG_SUSPEND      = 1;
  localparam int          FLG_AWAKE        = 2;
  localparam logic [6:0]  CONTROL_RESET    = 7'h00;

  typedef enum logic [1:0] {
    USD_TOK_SETUP = 2'b00,
    USD_TOK_OUT   = 2'b01,
    USD_TOK_IN    = 2'b10
  } usd_tok_e;

  typedef enum logic [1:0] {
    USD_HS_ACK   = 2'b00,
    USD_HS_NAK   = 2'b01,
    USD_HS_STALL = 2'b10,
    USD_HS_DATA  = 2'b11
  } usd_hs_e;

  typedef struct packed {
    logic               valid;
    logic [EP_BITS-1:0] ep;
    usd_tok_e           tok;
    logic [6:0]         len;
  } usd_txn_s;

  typedef struct packed {
    logic               valid;
    logic               set;
    logic [EP_BITS-1:0] ep;
  } usd_feat_s;

endpackage : usd_pkg

/* File: logic/usd_stall_dma_ctrl.sv */
`timescale 1ns/1ps
module usd_stall_dma_ctrl
  import usd_pkg::*;
#(
  parameter int NUM_EP = 4
) (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire usd_txn_s           txn,
  input  wire usd_feat_s          feat,
  input  wire logic               viol_valid,
  input  wire logic [EP_BITS-1:0] viol_ep,
  output logic                    hs_valid,
  output usd_hs_e                 hs_code,
  input  wire logic               tx_host_ack,
  input  wire logic               rx_byte_rd,
  input  wire logic               tx_byte_wr,
  output logic                    rx_dma_req,
  output logic                    tx_dma_req,
  input  wire logic               vbus_pin,
  input  wire logic               dp_pin,
  input  wire logic               dm_pin,
  output logic                    usb_bus_reset,
  output logic                    usb_powered,
  input  wire logic               suspend_evt,
  input  wire logic               awake_evt,
  input  wire logic               set_config_evt,
  output logic                    config_valid,
  output logic                    suspend_ext_interrupt,
  output logic                    wake_ext_interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]        pin_s1_r;
  logic [2:0]        pin_s2_r;
  logic              bus_reset_r;
  logic              powered_r;
  logic              ap_wr_r;
  logic [7:0]        ap_addr_r;
  logic [31:0]       hrdata_r;
  logic [NUM_EP-1:0] stall_req_r;
  logic              rx_dma_en_r;
  logic              tx_dma_en_r;
  logic              susp_route_r;
  logic [NUM_EP-1:0] stall_r;
  logic [NUM_EP-1:0] stall_nxt;
  logic              hs_valid_r;
  usd_hs_e           hs_code_r;
  usd_hs_e           hs_nxt;
  logic [6:0]        rx_cnt_r [2];
  logic [1:0]        rx_full_r;
  logic              rx_sel_r;
  logic [6:0]        tx_cnt_r [2];
  logic [1:0]        tx_full_r;
  logic              tx_wsel_r;
  logic              tx_rsel_r;
  logic [2:0]        flags_r;
  logic              cfg_valid_r;
  logic              susp_int_r;
  logic              wake_int_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: vbus, d+, d-
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {vbus_pin, dp_pin, dm_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_reset_r <= 1'b0;
      powered_r   <= 1'b0;
    end else begin
      bus_reset_r <= pin_s2_r[2] & ~pin_s2_r[1] & ~pin_s2_r[0];
      powered_r   <= pin_s2_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic ap_take;
  logic wr_control;
  logic wr_trigger;
  logic wr_flags;
  logic read_finish_trigger_pulse;
  logic packet_enable_trigger_pulse;

  assign ap_take    = hsel & htrans[1] & hready;
  assign wr_control = ap_wr_r & (ap_addr_r == ADDR_CONTROL);
  assign wr_trigger = ap_wr_r & (ap_addr_r == ADDR_TRIGGER);
  assign wr_flags   = ap_wr_r & (ap_addr_r == ADDR_FLAGS);
  assign read_finish_trigger_pulse = wr_trigger & hwdata[TRG_READ_FINISH];
  assign packet_enable_trigger_pulse = wr_trigger & hwdata[TRG_PACKET_EN];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_wr_r   <= ap_take & hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  logic [31:0] status_word;
  logic [31:0] rd_word;

  always_comb begin
    status_word                                = 32'h0;
    status_word[NUM_EP-1:0]                    = stall_r;
    status_word[ST_RX_REQ]                     = rx_dma_req;
    status_word[ST_TX_REQ]                     = tx_dma_req;
    status_word[ST_CFG_VALID]                  = cfg_valid_r;
    status_word[ST_BUS_RESET]                  = bus_reset_r;
    status_word[ST_POWERED]                    = powered_r;
    status_word[ST_RX_SEL]                     = rx_sel_r;
    status_word[ST_TX_WSEL]                    = tx_wsel_r;
    status_word[ST_TX_RSEL]                    = tx_rsel_r;
    status_word[ST_RX_FULL+1:ST_RX_FULL]       = rx_full_r;
    status_word[ST_TX_FULL+1:ST_TX_FULL]       = tx_full_r;
    status_word[ST_RX_CNT+6:ST_RX_CNT]         = rx_cnt_r[rx_sel_r];
    rd_word                                    = 32'h0;
    unique case (haddr[7:0])
      ADDR_CONTROL: begin
        rd_word[NUM_EP-1:0]    = stall_req_r;
        rd_word[CTL_RX_DMA]    = rx_dma_en_r;
        rd_word[CTL_TX_DMA]    = tx_dma_en_r;
        rd_word[CTL_SUSP_ROUTE] = susp_route_r;
      end
      ADDR_STATUS: rd_word = status_word;
      ADDR_FLAGS:  rd_word[2:0] = flags_r;
      default:     rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata_r <= 32'h0;
    end else if (ap_take & ~hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {susp_route_r, tx_dma_en_r, rx_dma_en_r, stall_req_r} <= CONTROL_RESET;
    end else if (wr_control) begin
      stall_req_r  <= hwdata[NUM_EP-1:0];
      rx_dma_en_r  <= hwdata[CTL_RX_DMA];
      tx_dma_en_r  <= hwdata[CTL_TX_DMA];
      susp_route_r <= hwdata[CTL_SUSP_ROUTE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction decode
  logic txn_setup0;
  logic stall_hit;
  logic rx_out;
  logic rx_both_full;
  logic rx_accept;
  logic rx_put;

  assign txn_setup0   = txn.valid & (txn.tok == USD_TOK_SETUP) & (txn.ep == EP_CTRL);
  assign stall_hit    = ~txn_setup0 & (stall_r[txn.ep] | stall_req_r[txn.ep]);
  assign rx_out       = txn.valid & (txn.ep == EP_RX) & (txn.tok == USD_TOK_OUT);
  assign rx_both_full = &rx_full_r;
  assign rx_accept    = rx_out & ~stall_hit & ~rx_both_full & ~(rx_dma_en_r & (txn.len == 7'h00));
  assign rx_put       = rx_full_r[rx_sel_r] ? ~rx_sel_r : rx_sel_r;

  always_comb begin
    hs_nxt = USD_HS_NAK;
    if (txn_setup0) begin
      hs_nxt = USD_HS_ACK;
    end else if (stall_hit) begin
      hs_nxt = USD_HS_STALL;
    end else if (txn.ep == EP_RX) begin
      hs_nxt = (rx_out & ~rx_both_full) ? USD_HS_ACK : USD_HS_NAK;
    end else if (txn.ep == EP_TX) begin
      hs_nxt = ((txn.tok == USD_TOK_IN) & tx_full_r[tx_rsel_r]) ? USD_HS_DATA : USD_HS_NAK;
    end else begin
      hs_nxt = (txn.tok == USD_TOK_IN) ? USD_HS_NAK : USD_HS_ACK;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hs_valid_r <= 1'b0;
      hs_code_r  <= USD_HS_ACK;
    end else begin
      hs_valid_r <= txn.valid;
      hs_code_r  <= hs_nxt;
    end
  end

  assign hs_valid = hs_valid_r;
  assign hs_code  = hs_code_r;

  ////////////////////////////////////////////////////////////////////////////
  // Internal stall bits
  always_comb begin
    stall_nxt = stall_r;
    if (feat.valid & ~feat.set) begin
      stall_nxt[feat.ep] = 1'b0;
    end
    if (txn.valid) begin
      if (txn_setup0) begin
        stall_nxt[EP_CTRL] = 1'b0;
      end else if (stall_req_r[txn.ep]) begin
        stall_nxt[txn.ep] = 1'b1;
      end
    end
    if (feat.valid & feat.set) begin
      stall_nxt[feat.ep] = 1'b1;
    end
    if (viol_valid) begin
      stall_nxt[viol_ep] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stall_r <= '0;
    end else if (bus_reset_r) begin
      stall_r <= '0;
    end else begin
      stall_r <= stall_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive endpoint, two sides
  logic rx_take;
  logic rx_fin;

  assign rx_take = rx_byte_rd & rx_full_r[rx_sel_r] & (rx_cnt_r[rx_sel_r] != 7'h00);
  assign rx_fin  = rx_full_r[rx_sel_r] &
                   ((rx_dma_en_r & rx_take & (rx_cnt_r[rx_sel_r] == 7'h01)) | read_finish_trigger_pulse);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_cnt_r[0] <= 7'h00;
      rx_cnt_r[1] <= 7'h00;
      rx_full_r   <= 2'h0;
      rx_sel_r    <= 1'b0;
    end else if (bus_reset_r) begin
      rx_cnt_r[0] <= 7'h00;
      rx_cnt_r[1] <= 7'h00;
      rx_full_r   <= 2'h0;
      rx_sel_r    <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_full_r[rx_put] <= 1'b1;
        rx_cnt_r[rx_put]  <= (txn.len > MAX_PKT) ? MAX_PKT : txn.len;
      end
      if (rx_take) begin
        rx_cnt_r[rx_sel_r] <= rx_cnt_r[rx_sel_r] - 7'h01;
      end
      if (rx_fin) begin
        rx_full_r[rx_sel_r] <= 1'b0;
        rx_cnt_r[rx_sel_r]  <= 7'h00;
        rx_sel_r            <= ~rx_sel_r;
      end
    end
  end

  assign rx_dma_req = rx_dma_en_r & rx_full_r[rx_sel_r] & (rx_cnt_r[rx_sel_r] != 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit endpoint, two sides
  logic tx_put;
  logic tx_arm;
  logic tx_sent;

  assign tx_put  = tx_byte_wr & ~tx_full_r[tx_wsel_r] & (tx_cnt_r[tx_wsel_r] < MAX_PKT);
  assign tx_arm  = ~tx_full_r[tx_wsel_r] &
                   ((tx_dma_en_r & tx_put & (tx_cnt_r[tx_wsel_r] == MAX_PKT - 7'h01)) | packet_enable_trigger_pulse);
  assign tx_sent = tx_host_ack & tx_full_r[tx_rsel_r];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_r[0] <= 7'h00;
      tx_cnt_r[1] <= 7'h00;
      tx_full_r   <= 2'h0;
      tx_wsel_r   <= 1'b0;
      tx_rsel_r   <= 1'b0;
    end else if (bus_reset_r) begin
      tx_cnt_r[0] <= 7'h00;
      tx_cnt_r[1] <= 7'h00;
      tx_full_r   <= 2'h0;
      tx_wsel_r   <= 1'b0;
      tx_rsel_r   <= 1'b0;
    end else begin
      if (tx_put) begin
        tx_cnt_r[tx_wsel_r] <= tx_cnt_r[tx_wsel_r] + 7'h01;
      end
      if (tx_arm) begin
        tx_full_r[tx_wsel_r] <= 1'b1;
        tx_wsel_r            <= ~tx_wsel_r;
      end
      if (tx_sent) begin
        tx_full_r[tx_rsel_r] <= 1'b0;
        tx_cnt_r[tx_rsel_r]  <= 7'h00;
        tx_rsel_r            <= ~tx_rsel_r;
      end
    end
  end

  assign tx_dma_req = tx_dma_en_r & ~tx_full_r[tx_wsel_r];

  ////////////////////////////////////////////////////////////////////////////
  // Event flags, write one to clear, set wins
  logic [2:0] flag_set;

  assign flag_set = {awake_evt, suspend_evt, set_config_evt};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= (flags_r & ~(wr_flags ? hwdata[2:0] : 3'h0)) | flag_set;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_valid_r <= 1'b0;
    end else if (set_config_evt) begin
      cfg_valid_r <= 1'b1;
    end else if (bus_reset_r) begin
      cfg_valid_r <= 1'b0;
    end
  end

  assign config_valid = cfg_valid_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      susp_int_r <= 1'b0;
      wake_int_r <= 1'b0;
    end else begin
      susp_int_r <= susp_route_r & flags_r[FLG_SUSPEND];
      wake_int_r <= susp_route_r & flags_r[FLG_AWAKE];
    end
  end

  assign suspend_ext_interrupt = susp_int_r;
  assign wake_ext_interrupt    = wake_int_r;
  assign usb_bus_reset         = bus_reset_r;
  assign usb_powered           = powered_r;

endmodule : usd_stall_dma_ctrl

/* File: bench/usd_monitor.sv */
`timescale 1ns/1ps
module usd_monitor
  import usd_pkg::*;
#(
  parameter int NUM_EP = 4
) (
  input wire logic               clock,
  input wire logic               resetn,
  input wire usd_txn_s           txn,
  input wire usd_feat_s          feat,
  input wire logic               viol_valid,
  input wire logic [EP_BITS-1:0] viol_ep,
  input wire logic               hs_valid,
  input wire usd_hs_e            hs_code,
  input wire logic               vbus_pin,
  input wire logic               dp_pin,
  input wire logic               dm_pin,
  input wire logic               usb_bus_reset,
  input wire logic               usb_powered,
  input wire logic               set_config_evt,
  input wire logic               config_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  property p_hs; txn.valid |=> hs_valid; endproperty
  a_hs: assert property (p_hs) else $error("token not answered");
  property p_hs_cause; hs_valid |-> $past(txn.valid); endproperty
  a_hs_cause: assert property (p_hs_cause) else $error("answer without token");
  property p_halt;
    feat.valid && feat.set ##2 txn.valid && txn.ep == $past(feat.ep, 2) && txn.tok != USD_TOK_SETUP
      |=> hs_code == USD_HS_STALL;
  endproperty
  a_halt: assert property (p_halt) else $error("halted endpoint not stalled");
  property p_viol;
    viol_valid ##2 txn.valid && txn.ep == $past(viol_ep, 2) && txn.tok != USD_TOK_SETUP
      |=> hs_code == USD_HS_STALL;
  endproperty
  a_viol: assert property (p_viol) else $error("violation not stalled");
  property p_setup; txn.valid && txn.ep == EP_CTRL && txn.tok == USD_TOK_SETUP |=> hs_code == USD_HS_ACK; endproperty
  a_setup: assert property (p_setup) else $error("setup not accepted");
  property p_line_reset; (vbus_pin && !dp_pin && !dm_pin) [*5] |-> usb_bus_reset; endproperty
  a_line_reset: assert property (p_line_reset) else $error("low lines not a bus reset");
  property p_vbus_low; (!vbus_pin) [*5] |-> !usb_powered && !usb_bus_reset; endproperty
  a_vbus_low: assert property (p_vbus_low) else $error("lines not ignored");
  property p_cfg; set_config_evt |=> ##[0:2] config_valid; endproperty
  a_cfg: assert property (p_cfg) else $error("config valid missing");
endmodule : usd_monitor

bind usd_stall_dma_ctrl usd_monitor #(.NUM_EP(NUM_EP)) usd_monitor_inst (
  .clock, .resetn, .txn, .feat, .viol_valid, .viol_ep, .hs_valid, .hs_code, .vbus_pin,
  .dp_pin, .dm_pin, .usb_bus_reset, .usb_powered, .set_config_evt, .config_valid);

/* File: bench/usd_host_model.sv */
`timescale 1ns/1ps
module usd_host_model
  import usd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          hs_valid,
  input  wire usd_hs_e       hs_code,
  output usd_txn_s           txn,
  output usd_feat_s          feat,
  output logic               viol_valid,
  output logic [EP_BITS-1:0] viol_ep,
  output logic               tx_host_ack,
  output logic               vbus_pin,
  output logic               dp_pin,
  output logic               dm_pin
);
  initial begin
    {txn, feat, viol_valid, viol_ep, tx_host_ack} = '0;
    {vbus_pin, dp_pin, dm_pin} = 3'b110;
  end
  ////////////////////////////////////////
  // Answer sampled in its only cycle
  task automatic token(input logic [1:0] ep, input usd_tok_e tok, input logic [6:0] len, output usd_hs_e hs);
    @(posedge clock);
    txn <= '{1'b1, ep, tok, len};
    @(posedge clock);
    txn <= '0;
    #1;
    hs = hs_code;
  endtask : token
  task automatic feature(input logic set, input logic [1:0] ep);
    @(posedge clock);
    feat <= '{1'b1, set, ep};
    @(posedge clock);
    feat <= '0;
  endtask : feature
  task automatic violate(input logic [1:0] ep);
    @(posedge clock);
    {viol_valid, viol_ep} <= {1'b1, ep};
    @(posedge clock);
    viol_valid <= 1'b0;
  endtask : violate
  task automatic ack_in;
    @(posedge clock);
    tx_host_ack <= 1'b1;
    @(posedge clock);
    tx_host_ack <= 1'b0;
  endtask : ack_in
  task automatic lines(input logic [2:0] v);
    @(posedge clock);
    {vbus_pin, dp_pin, dm_pin} <= v;
  endtask : lines
endmodule : usd_host_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import usd_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0]  ev = 5'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, hs_valid, rx_dma_req, tx_dma_req, usb_bus_reset, usb_powered;
  logic        config_valid, suspend_ext_interrupt, wake_ext_interrupt, viol_valid, tx_host_ack;
  logic        vbus_pin, dp_pin, dm_pin;
  logic [1:0]  viol_ep;
  usd_hs_e     hs_code;
  usd_txn_s    txn;
  usd_feat_s   feat;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clock = ~clock;

  usd_stall_dma_ctrl #(.NUM_EP(4)) usd_stall_dma_ctrl_inst (
    .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .txn, .feat, .viol_valid, .viol_ep, .hs_valid, .hs_code,
    .tx_host_ack, .rx_byte_rd(ev[3]), .tx_byte_wr(ev[4]), .rx_dma_req, .tx_dma_req, .vbus_pin,
    .dp_pin, .dm_pin, .usb_bus_reset, .usb_powered, .suspend_evt(ev[0]), .awake_evt(ev[1]),
    .set_config_evt(ev[2]), .config_valid, .suspend_ext_interrupt, .wake_ext_interrupt);

  usd_host_model usd_host_model_inst (
    .clock, .hs_valid, .hs_code, .txn, .feat, .viol_valid, .viol_ep, .tx_host_ack,
    .vbus_pin, .dp_pin, .dm_pin);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : bchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task pulse(input int b, input int n);
    @(posedge clock);
    ev[b] <= 1'b1;
    repeat (n) @(posedge clock);
    ev[b] <= 1'b0;
    #1;
  endtask : pulse
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 24'h0, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
    #1;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(n, e, v);
  endtask : rdc
  task automatic sb(input string n, input int b, input logic e);
    logic [31:0] v;
    ahb(1'b0, ADDR_STATUS, 32'h0, v);
    bchk(n, e, v[b]);
  endtask : sb
  task automatic tk(input logic [1:0] ep, input usd_tok_e t, input logic [6:0] n, input usd_hs_e e);
    usd_hs_e h;
    usd_host_model_inst.token(ep, t, n, h);
    chk("handshake", {30'h0, e}, {30'h0, h});
  endtask : tk
  task automatic ft(input logic s, input logic [1:0] ep);
    usd_host_model_inst.feature(s, ep);
  endtask : ft
  ////////////////////////////////////////
  task automatic t_forced;
    wr(ADDR_CONTROL, 32'h8);
    sb("stall3", 3, 1'b0);
    tk(2'h3, USD_TOK_OUT, 7'h1, USD_HS_STALL);
    sb("stall3", 3, 1'b1);
    ft(1'b0, 2'h3);
    tk(2'h3, USD_TOK_OUT, 7'h1, USD_HS_STALL);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_STATUS, 32'h0);
    sb("stall3", 3, 1'b1);
    ft(1'b0, 2'h3);
    tk(2'h3, USD_TOK_OUT, 7'h1, USD_HS_ACK);
    sb("stall3", 3, 1'b0);
  endtask : t_forced
  task automatic t_auto;
    ft(1'b1, 2'h0);
    tk(2'h0, USD_TOK_OUT, 7'h0, USD_HS_STALL);
    tk(2'h0, USD_TOK_SETUP, 7'h8, USD_HS_ACK);
    tk(2'h0, USD_TOK_OUT, 7'h0, USD_HS_ACK);
    usd_host_model_inst.violate(2'h3);
    tk(2'h3, USD_TOK_IN, 7'h0, USD_HS_STALL);
    ft(1'b0, 2'h3);
    tk(2'h3, USD_TOK_IN, 7'h0, USD_HS_NAK);
  endtask : t_auto
  task automatic t_rx;
    logic [31:0] v;
    tk(2'h1, USD_TOK_OUT, 7'h40, USD_HS_ACK);
    tk(2'h1, USD_TOK_OUT, 7'h40, USD_HS_ACK);
    tk(2'h1, USD_TOK_OUT, 7'h1, USD_HS_NAK);
    wr(ADDR_TRIGGER, 32'h1);
    wr(ADDR_TRIGGER, 32'h1);
    wr(ADDR_CONTROL, 32'h10);
    bchk("rx_req", 1'b0, rx_dma_req);
    tk(2'h1, USD_TOK_OUT, 7'h0, USD_HS_ACK);
    bchk("rx_req", 1'b0, rx_dma_req);
    ahb(1'b0, ADDR_STATUS, 32'h0, v);
    chk("rx_full", 32'h0, {30'h0, v[ST_RX_FULL+1:ST_RX_FULL]});
    tk(2'h1, USD_TOK_OUT, 7'h3, USD_HS_ACK);
    bchk("rx_req", 1'b1, rx_dma_req);
    pulse(3, 3);
    bchk("rx_req", 1'b0, rx_dma_req);
    sb("rx_sel", ST_RX_SEL, ~v[ST_RX_SEL]);
    wr(ADDR_CONTROL, 32'h0);
  endtask : t_rx
  task automatic t_tx;
    logic [31:0] v;
    wr(ADDR_CONTROL, 32'h20);
    bchk("tx_req", 1'b1, tx_dma_req);
    tk(2'h2, USD_TOK_IN, 7'h0, USD_HS_NAK);
    ahb(1'b0, ADDR_STATUS, 32'h0, v);
    pulse(4, 64);
    tk(2'h2, USD_TOK_IN, 7'h0, USD_HS_DATA);
    sb("tx_side", ST_TX_WSEL, ~v[ST_TX_WSEL]);
    ft(1'b1, 2'h2);
    tk(2'h2, USD_TOK_IN, 7'h0, USD_HS_STALL);
    ft(1'b0, 2'h2);
    usd_host_model_inst.ack_in();
    cyc(1);
    bchk("tx_req", 1'b1, tx_dma_req);
    wr(ADDR_CONTROL, 32'h0);
    bchk("tx_req", 1'b0, tx_dma_req);
    pulse(4, 5);
    wr(ADDR_TRIGGER, 32'h2);
    tk(2'h2, USD_TOK_IN, 7'h0, USD_HS_DATA);
  endtask : t_tx
  task automatic t_misc;
    wr(ADDR_CONTROL, 32'h40);
    rdc("control", ADDR_CONTROL, 32'h40);
    rdc("unmapped", 8'h10, 32'h0);
    rdc("trigger", ADDR_TRIGGER, 32'h0);
    bchk("hresp", 1'b0, hresp);
    bchk("hreadyout", 1'b1, hreadyout);
    pulse(0, 1);
    cyc(2);
    bchk("susp_irq", 1'b1, suspend_ext_interrupt);
    bchk("wake_irq", 1'b0, wake_ext_interrupt);
    pulse(1, 1);
    cyc(2);
    bchk("wake_irq", 1'b1, wake_ext_interrupt);
    pulse(2, 1);
    cyc(2);
    bchk("cfg_valid", 1'b1, config_valid);
    rdc("flags", ADDR_FLAGS, 32'h7);
    wr(ADDR_CONTROL, 32'h0);
    cyc(2);
    bchk("susp_irq", 1'b0, suspend_ext_interrupt);
    wr(ADDR_FLAGS, 32'h7);
    rdc("flags", ADDR_FLAGS, 32'h0);
  endtask : t_misc
  task automatic t_pins;
    usd_host_model_inst.lines(3'b100);
    cyc(5);
    bchk("bus_reset", 1'b1, usb_bus_reset);
    bchk("cfg_valid", 1'b0, config_valid);
    usd_host_model_inst.lines(3'b010);
    cyc(5);
    bchk("powered", 1'b0, usb_powered);
    bchk("bus_reset", 1'b0, usb_bus_reset);
    usd_host_model_inst.lines(3'b110);
    cyc(5);
    bchk("powered", 1'b1, usb_powered);
  endtask : t_pins
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    cyc(4);
    t_forced();
    t_auto();
    t_rx();
    t_tx();
    t_misc();
    t_pins();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
endmodule : tb
